/* rtl/lpmrs_core.v */
// low-power mode control, break exit and reset source status block
// What this block does
// - entering wait or stop clears the interrupt mask bit
// - wait mode stops cpu clocks, peripheral clocks keep running
// - enabled interrupt in wait wakes cpu and starts stacking, both one cycle later
// - reset or break interrupt also ends wait mode
// - break ending wait or stop sets the break exit flag
// - watchdog stays enabled in wait when disable option is zero
// - stop mode resets the counter and gates the clock generator output
// - stop ends on interrupt, reset or break; interrupt stacking after recovery
// - recovery is 4096 cycles, or 32 with short recovery selected
// - counter held clear from stop until recovery begins, then times it
// - writing zero clears break exit flag; reset clears it too
// - reset source register flags last cause; a read clears all flags
// - power-on sets power-on flag and clears all others
// - pin, watchdog, illegal opcode, low voltage, illegal fetch each flag
// - monitor entry with erased vector sets its own flag
// - break clear enable gates status clears during break
// - flags cleared in break stay cleared afterwards
`timescale 1ns/1ps
`default_nettype none
`include "lpmrs_regs.vh"
module lpmrs_core (
	input  wire        clock,
	input  wire        nrst,
	input  wire        clkEn,
	input  wire [15:0] addr,
	input  wire [7:0]  wrData,
	input  wire        wrStb,
	input  wire        rdStb,
	output reg  [7:0]  rdData,
	input  wire        waitExec,
	input  wire        stopExec,
	input  wire        intReq,
	input  wire        breakInt,
	input  wire        breakState,
	input  wire        shortRecoverySelect,
	input  wire        watchdogDisableOption,
	input  wire        porEvent,
	input  wire        pinResetEvent,
	input  wire        watchdogResetEvent,
	input  wire        illegalOpcodeEvent,
	input  wire        illegalAddressEvent,
	input  wire        lowVoltageEvent,
	input  wire        monitorEntryEvent,
	output reg         clearIntMask,
	output reg         cpuClockEn,
	output reg         periphClockEn,
	output reg         clockGenOutEn,
	output reg         stackStart,
	output reg         watchdogRun,
	output reg         inWait,
	output reg         inStop
);
	//////////////////////////////////////////////////////////////////
	// mode state machine
	localparam [1:0] ST_RUN = 2'b00;
	localparam [1:0] ST_WAIT = 2'b01;
	localparam [1:0] ST_STOP = 2'b10;
	localparam [1:0] ST_RECOV = 2'b11;
	reg  [1:0] state_reg;
	reg  [1:0] state_next;
	reg        recBreak_reg;
	wire       recDone;
	wire       anyReset;
	assign anyReset = porEvent | pinResetEvent | watchdogResetEvent | illegalOpcodeEvent |
		illegalAddressEvent | lowVoltageEvent | monitorEntryEvent;
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (stopExec)
					state_next = ST_STOP;
				else if (waitExec)
					state_next = ST_WAIT;
			end
			ST_WAIT: begin
				if (intReq || breakInt)
					state_next = ST_RUN;
			end
			ST_STOP: begin
				if (intReq || breakInt)
					state_next = ST_RECOV;
			end
			ST_RECOV: begin
				if (recDone)
					state_next = ST_RUN;
			end
			default: state_next = ST_RUN;
		endcase
		if (anyReset)
			state_next = ST_RUN;
	end
	lpmrs_recovery_counter recCounter (
		.clock     (clock),
		.nrst      (nrst),
		.clkEn     (clkEn),
		.holdClear (state_reg != ST_RECOV),
		.run       (state_reg == ST_RECOV),
		.shortSel  (shortRecoverySelect),
		.done      (recDone)
	);
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_reg     <= ST_RUN;
			recBreak_reg  <= 1'b0;
			clearIntMask  <= 1'b0;
			cpuClockEn    <= 1'b1;
			periphClockEn <= 1'b1;
			clockGenOutEn <= 1'b1;
			stackStart    <= 1'b0;
			watchdogRun   <= 1'b0;
			inWait        <= 1'b0;
			inStop        <= 1'b0;
		end else if (clkEn) begin
			state_reg     <= state_next;
			if (state_reg == ST_STOP && state_next == ST_RECOV)
				recBreak_reg <= breakInt;
			clearIntMask  <= (state_reg == ST_RUN) && (stopExec || waitExec) && !anyReset;
			cpuClockEn    <= state_next == ST_RUN;
			periphClockEn <= (state_next == ST_RUN) || (state_next == ST_WAIT);
			clockGenOutEn <= (state_next == ST_RUN) || (state_next == ST_WAIT);
			stackStart    <= !anyReset && (((state_reg == ST_WAIT) && intReq && !breakInt) ||
				((state_reg == ST_RECOV) && recDone && !recBreak_reg));
			watchdogRun   <= !watchdogDisableOption && (state_next != ST_STOP) && (state_next != ST_RECOV);
			inWait        <= state_next == ST_WAIT;
			inStop        <= (state_next == ST_STOP) || (state_next == ST_RECOV);
		end
	end
	//////////////////////////////////////////////////////////////////
	// status registers
	reg        brkExit_reg;
	reg        brkClrEn_reg;
	reg  [7:0] rstSrc_reg;
	reg  [7:0] rstSrc_next;
	wire       clrAllowed;
	wire       brkExitEvent;
	wire       wrBrkStat;
	wire       rdRstSrc;
	assign clrAllowed   = !breakState || brkClrEn_reg;
	assign brkExitEvent = breakInt && ((state_reg == ST_WAIT) || (state_reg == ST_STOP));
	assign wrBrkStat    = wrStb && (addr == `LPMRS_OFF_BRKSTAT);
	assign rdRstSrc     = rdStb && (addr == `LPMRS_OFF_RSTSRC);
	always @* begin
		rstSrc_next = rstSrc_reg;
		if (rdRstSrc && clrAllowed)
			rstSrc_next = 8'h00;
		if (pinResetEvent)
			rstSrc_next[`LPMRS_BIT_PIN] = 1'b1;
		if (watchdogResetEvent)
			rstSrc_next[`LPMRS_BIT_WDOG] = 1'b1;
		if (illegalOpcodeEvent)
			rstSrc_next[`LPMRS_BIT_ILLEGAL_OPCODE_FLAG] = 1'b1;
		if (illegalAddressEvent)
			rstSrc_next[`LPMRS_BIT_ILLEGAL_ADDRESS_FLAG] = 1'b1;
		if (lowVoltageEvent)
			rstSrc_next[`LPMRS_BIT_LVI] = 1'b1;
		if (monitorEntryEvent)
			rstSrc_next[`LPMRS_BIT_MONITOR_ENTRY_RESET_FLAG] = 1'b1;
		if (porEvent)
			rstSrc_next = `LPMRS_RST_RSTSRC;
	end
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			brkExit_reg  <= 1'b0;
			brkClrEn_reg <= 1'b0;
			rstSrc_reg   <= `LPMRS_RST_RSTSRC;
		end else if (clkEn) begin
			rstSrc_reg <= rstSrc_next;
			if (anyReset)
				brkExit_reg <= 1'b0;
			else if (brkExitEvent)
				brkExit_reg <= 1'b1;
			else if (wrBrkStat && !wrData[`LPMRS_BIT_BRKEXIT] && clrAllowed)
				brkExit_reg <= 1'b0;
			if (anyReset)
				brkClrEn_reg <= 1'b0;
			else if (wrStb && (addr == `LPMRS_OFF_BRKCTL))
				brkClrEn_reg <= wrData[`LPMRS_BIT_BRKCLREN];
		end
	end
	//////////////////////////////////////////////////////////////////
	// read port
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdData <= 8'h00;
		end else if (clkEn) begin
			rdData <= 8'h00;
			if (rdStb) begin
				case (addr)
					`LPMRS_OFF_BRKSTAT: rdData <= {6'h00, brkExit_reg, 1'b0};
					`LPMRS_OFF_RSTSRC: rdData <= rstSrc_reg;
					`LPMRS_OFF_BRKCTL: rdData <= {brkClrEn_reg, 7'h00};
					default: rdData <= 8'h00;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* rtl/lpmrs_recovery_counter.v */
// stop recovery counter: held clear, then counts to the selected terminal count
`timescale 1ns/1ps
`default_nettype none
`include "lpmrs_regs.vh"
module lpmrs_recovery_counter (
	input  wire        clock,
	input  wire        nrst,
	input  wire        clkEn,
	input  wire        holdClear,
	input  wire        run,
	input  wire        shortSel,
	output reg         done
);
	reg  [`LPMRS_CNT_W-1:0] count_reg;
	wire [`LPMRS_CNT_W-1:0] termCount;
	assign termCount = shortSel ? `LPMRS_REC_SHORT : `LPMRS_REC_LONG;
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			count_reg <= 13'h0000;
			done      <= 1'b0;
		end else if (clkEn) begin
			if (holdClear) begin
				count_reg <= 13'h0000;
				done      <= 1'b0;
			end else if (run && !done) begin
				count_reg <= count_reg + 13'h0001;
				done      <= (count_reg + 13'h0001) == termCount;
			end
		end
	end
endmodule
`default_nettype wire

/* rtl/lpmrs_regs.vh */
// register offsets, field positions and timing counts of the low-power and reset status block
`ifndef LPMRS_REGS_VH
`define LPMRS_REGS_VH
`define LPMRS_ADDR_W          16
`define LPMRS_OFF_BRKSTAT     16'hfe00
`define LPMRS_OFF_RSTSRC      16'hfe01
`define LPMRS_OFF_BRKCTL      16'hfe03
`define LPMRS_BIT_BRKEXIT     1
`define LPMRS_BIT_BRKCLREN    7
`define LPMRS_BIT_LVI         1
`define LPMRS_BIT_MONITOR_ENTRY_RESET_FLAG      2
`define LPMRS_BIT_ILLEGAL_ADDRESS_FLAG        3
`define LPMRS_BIT_ILLEGAL_OPCODE_FLAG        4
`define LPMRS_BIT_WDOG        5
`define LPMRS_BIT_PIN         6
`define LPMRS_BIT_POR         7
`define LPMRS_RST_BRKSTAT     8'h00
`define LPMRS_RST_BRKCTL      8'h00
`define LPMRS_RST_RSTSRC      8'h80
`define LPMRS_REC_LONG        13'h1000
`define LPMRS_REC_SHORT       13'h0020
`define LPMRS_CNT_W           13
`endif

/* sim/lpmrs_cpu_model.sv */
// far-side model: cpu core and waking module, raises a wake source while clocks are stopped
`timescale 1ns/1ps
`default_nettype none
module lpmrs_cpu_model (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       cpuClockEn,
	input  wire logic       clockGenOutEn,
	input  wire logic       useBreak,
	input  wire logic [7:0] wakeDelay,
	output var  logic       intReq,
	output var  logic       breakInt
);
	logic [7:0] cntReg;
	// source held until the cpu runs again
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cntReg <= 8'h00;
			intReq <= 1'b0;
			breakInt <= 1'b0;
		end else if (cpuClockEn && clockGenOutEn) begin
			cntReg <= 8'h00;
			intReq <= 1'b0;
			breakInt <= 1'b0;
		end else if (cntReg == wakeDelay) begin
			intReq <= !useBreak;
			breakInt <= useBreak;
		end else
			cntReg <= cntReg + 8'h01;
	end
endmodule
`default_nettype wire

/* sim/lpmrs_sva.sv */
// assertions of the low-power and reset status block
`timescale 1ns/1ps
`default_nettype none
module lpmrs_sva (
	input wire logic clock,
	input wire logic nrst,
	input wire logic clkEn,
	input wire logic intReq,
	input wire logic breakInt,
	input wire logic shortRecoverySelect,
	input wire logic watchdogDisableOption,
	input wire logic clearIntMask,
	input wire logic cpuClockEn,
	input wire logic periphClockEn,
	input wire logic clockGenOutEn,
	input wire logic stackStart,
	input wire logic watchdogRun,
	input wire logic inWait,
	input wire logic inStop
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	AST_WAIT: assert property ($rose(inWait) |-> !cpuClockEn && periphClockEn && clearIntMask) else $error("wait");
	AST_WAKE: assert property (inWait && intReq && !breakInt && clkEn |=> cpuClockEn && stackStart) else $error("wake");
	AST_BRK: assert property (inWait && breakInt && clkEn |=> !inWait && cpuClockEn) else $error("break");
	AST_WDOG: assert property (inWait && !watchdogDisableOption |-> watchdogRun) else $error("watchdog");
	AST_WDOFF: assert property (watchdogDisableOption && clkEn |=> !watchdogRun) else $error("watchdog off");
	AST_STOP: assert property ($rose(inStop) |-> !clockGenOutEn && clearIntMask) else $error("stop");
	AST_RET: assert property ($fell(inStop) |-> clockGenOutEn && cpuClockEn) else $error("return");
	AST_STACK: assert property ($rose(clockGenOutEn) && intReq |-> stackStart) else $error("stack");
	AST_REC: assert property ($fell(inStop) && shortRecoverySelect |-> $past(intReq || breakInt, 33)) else $error("recovery");
	cover property ($rose(inStop));
	cover property (stackStart);
	cover property ($fell(inWait));
endmodule
bind lpmrs_core lpmrs_sva chk_u (.*);
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench of the low-power and reset status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clock = 0, nrst = 0, wrStb = 0, rdStb = 0, waitExec = 0, stopExec = 0, brkState = 0, useBrk = 0, rdWas = 0;
	logic shortRecoverySelect = 0, intReq, breakInt, clearIntMask, cpuClockEn, periphClockEn, clockGenOutEn;
	logic stackStart, watchdogRun, inWait, inStop;
	logic clkEn = 1, wdDis = 0;
	logic [7:0] rnd;
	logic [15:0] addr = 0;
	logic [7:0] wrData = 0, rdData, wd = 8;
	logic [7:1] ev = 0;
	logic [7:0] expQ[$];
	int bad_count = 0, check_count = 0, n;
	initial forever #10 clock = ~clock;
	lpmrs_core dut_u (.clock(clock), .nrst(nrst), .clkEn(clkEn), .addr(addr), .wrData(wrData), .wrStb(wrStb),
		.rdStb(rdStb), .rdData(rdData), .waitExec(waitExec), .stopExec(stopExec), .intReq(intReq), .breakInt(breakInt),
		.breakState(brkState), .shortRecoverySelect(shortRecoverySelect), .watchdogDisableOption(wdDis),
		.porEvent(ev[7]), .pinResetEvent(ev[6]), .watchdogResetEvent(ev[5]), .illegalOpcodeEvent(ev[4]),
		.illegalAddressEvent(ev[3]), .lowVoltageEvent(ev[1]), .monitorEntryEvent(ev[2]), .clearIntMask(clearIntMask),
		.cpuClockEn(cpuClockEn), .periphClockEn(periphClockEn), .clockGenOutEn(clockGenOutEn), .stackStart(stackStart),
		.watchdogRun(watchdogRun), .inWait(inWait), .inStop(inStop));
	lpmrs_cpu_model far_u (.clock(clock), .nrst(nrst), .cpuClockEn(cpuClockEn), .clockGenOutEn(clockGenOutEn),
		.useBreak(useBrk), .wakeDelay(wd), .intReq(intReq), .breakInt(breakInt));
	task automatic chk(input logic [15:0] e, g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chkWake(input int got, lo, hi);
		check_count++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("ERROR %0t: wake after %0d cycles, allowed %0d to %0d", $time, got, lo, hi);
		end
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// one write or one read; a read notes its expected data
	task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wrData <= d;
		wrStb <= w;
		rdStb <= !w;
		if (!w) expQ.push_back(d);
		@(posedge clock);
		wrStb <= 0;
		rdStb <= 0;
	endtask
	// enter wait or stop, let the far side wake it, measure the wake time
	task automatic lp(input logic stp, brk, input int lo, hi);
		@(posedge clock);
		stopExec <= stp;
		waitExec <= !stp;
		useBrk <= brk;
		wd <= 8'($urandom_range(40, 3));
		@(posedge clock);
		stopExec <= 0;
		waitExec <= 0;
		for (n = 0; n < 6000 && intReq !== 1 && breakInt !== 1; n++) @(negedge clock);
		for (n = 0; n < 6000 && !(cpuClockEn === 1 && clockGenOutEn === 1); n++) @(negedge clock);
		@(posedge clock);
		chkWake(n, lo, hi);
		if (n == 6000) conclude();
	endtask
	always @(posedge clock) rdWas <= rdStb;
	always @(negedge clock) if (rdWas) chk(16'(expQ.pop_front()), 16'(rdData));
	initial begin
		repeat (60000) @(posedge clock);
		bad_count++;
		conclude();
	end
	initial begin
		void'($urandom(32'h22133c08));
		repeat (2) @(posedge clock);
		nrst <= 1;
		bus(0, 16'hfe01, 8'h80);
		bus(0, 16'hfe01, 8'h00);
		bus(0, 16'hfe02, 8'h00);
		bus(0, 16'hfe03, 8'h00);
		for (int b = 1; b < 8; b++) begin
			@(posedge clock);
			ev[b] <= 1;
			@(posedge clock);
			ev <= 0;
			bus(0, 16'hfe01, 8'h01 << b);
		end
		lp(0, 0, 1, 2);
		wdDis <= 1;
		lp(0, 0, 1, 2);
		wdDis <= 0;
		shortRecoverySelect <= 1;
		lp(1, 0, 32, 36);
		shortRecoverySelect <= 0;
		lp(1, 0, 4096, 4100);
		lp(0, 1, 1, 2);
		bus(0, 16'hfe00, 8'h02);
		brkState <= 1;
		bus(1, 16'hfe00, 8'h00);
		bus(0, 16'hfe00, 8'h02);
		bus(1, 16'hfe03, 8'h80);
		bus(0, 16'hfe03, 8'h80);
		bus(1, 16'hfe00, 8'h00);
		brkState <= 0;
		bus(0, 16'hfe00, 8'h00);
		// a write while the clock enable is low must be lost
		clkEn <= 0;
		bus(1, 16'hfe03, 8'h00);
		clkEn <= 1;
		bus(0, 16'hfe03, 8'h80);
		rnd = 8'($urandom);
		bus(1, 16'hfe03, rnd);
		bus(0, 16'hfe03, rnd & 8'h80);
		shortRecoverySelect <= 1;
		lp(1, 1, 32, 36);
		bus(0, 16'hfe00, 8'h02);
		@(posedge clock);
		ev[6] <= 1;
		@(posedge clock);
		ev <= 0;
		bus(0, 16'hfe00, 8'h00);
		conclude();
	end
endmodule
`default_nettype wire
